//--- hw/mcm_pkg.sv
// package: register map and constants of the monitor channel mode control
package mcm_pkg;
  localparam logic [7:0] ADDR_SKIP = 8'h08;
  localparam logic [7:0] ADDR_SHOT = 8'h09;
  localparam logic [7:0] ADDR_DEEP = 8'h0A;
  localparam logic [7:0] ADDR_CFG = 8'h0B;
  localparam logic [7:0] RST_SKIP = 8'h00;
  localparam logic [7:0] RST_DEEP = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam int SHOT_BIT = 0;
  localparam int DEEP_BIT = 0;
  localparam int REF_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int TEMP_BIT = 7;
  localparam logic [7:0] RSV_MODE2 = 8'h70;
  localparam logic [7:0] RSV_MODE3 = 8'h40;
  localparam int NUM_SLOTS = 8;
  typedef enum logic [1:0] {
    MODE_0, MODE_1, MODE_2, MODE_3
  } mcm_mode_t;
  typedef enum {
    ST_SHUTDOWN, ST_DEEP, ST_RUN, ST_SHOT
  } mcm_state_t;
endpackage

//--- hw/mcm_ctrl.sv
// module: skip mask, single shot, deep sleep and pairing configuration
// ---------------------------------------------------------------------------
// Contract
// RQ1 - host writes the skip mask only while the run bit is 0
// RQ2 - skip mask write clears all results and interrupt status
// RQ3 - skipped slot is not converted, reads 0, raises no limit event
// RQ4 - modes 0/1: bits 0-6 inputs 0-6; bit 7 temperature or input 7
// RQ5 - mode 2: bits 0-3 pairs, bits 4-6 reserved, bit 7 temperature
// RQ6 - mode 3: bits 0-3 singles, bits 4-5 pairs, bit 6 reserved
// RQ7 - writing 1 to shot bit in shutdown starts one full pass
// RQ8 - after the pass, return to shutdown or deep shutdown as before
// RQ9 - deep bit set with run bit 0 enters deep shutdown
// RQ10 - configuration write clears all results and interrupt status
// RQ11 - configuration bit 0 picks internal 0 or external 1 reference
// RQ12 - configuration bits 2:1 pick pairing modes 0 to 3
// RQ13 - shot register reads 0; writing 0 does nothing
// RQ14 - converting flag is 1 while any conversion runs
// ---------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module mcm_ctrl
  import mcm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic run_bit,
  input wire logic pass_done,
  input wire logic [7:0] slot_event,
  output logic clear_results,
  output logic [7:0] slot_enable,
  output logic [7:0] slot_event_ok,
  output logic pass_start,
  output logic converting,
  output logic deep_sleep,
  output logic ext_ref_sel,
  output mcm_pkg::mcm_mode_t pair_mode
);
  import mcm_pkg::*;

  // ---------------------------------------------------------------------
  // reserved bits by mode
  // ---------------------------------------------------------------------
  function automatic logic [7:0] rsv_mask(input mcm_mode_t m);
    case (m)
      MODE_2: rsv_mask = RSV_MODE2; // [RQ5]
      MODE_3: rsv_mask = RSV_MODE3; // [RQ6]
      default: rsv_mask = 8'h00; // [RQ4]
    endcase
  endfunction

  logic [7:0] skip_r, skip_nxt;
  logic deep_r, deep_nxt;
  logic ref_r, ref_nxt;
  mcm_mode_t mode_r, mode_nxt;
  mcm_state_t st_r, st_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic hit_r, hit_nxt;
  logic clr_r, clr_nxt;
  logic start_r, start_nxt;
  logic [7:0] en_r, en_nxt;
  logic [7:0] evok_r, evok_nxt;
  logic conv_r, conv_nxt;
  logic dsl_r, dsl_nxt;
  logic [7:0] rsv_nxt;
  logic wr_skip, wr_shot, wr_deep, wr_cfg, any_hit;

  assign wr_skip = reg_wr && (reg_addr == ADDR_SKIP);
  assign wr_shot = reg_wr && (reg_addr == ADDR_SHOT);
  assign wr_deep = reg_wr && (reg_addr == ADDR_DEEP);
  assign wr_cfg = reg_wr && (reg_addr == ADDR_CFG);
  assign any_hit = (reg_addr == ADDR_SKIP) || (reg_addr == ADDR_SHOT) ||
                   (reg_addr == ADDR_DEEP) || (reg_addr == ADDR_CFG);

  // ---------------------------------------------------------------------
  // registers and power state
  // ---------------------------------------------------------------------
  always_comb begin
    skip_nxt = skip_r;
    deep_nxt = deep_r;
    ref_nxt = ref_r;
    mode_nxt = mode_r;
    st_nxt = st_r;
    start_nxt = 1'b0;
    // skip mask is only legal in shutdown; host keeps to it [RQ1]
    if (wr_skip) begin
      skip_nxt = reg_wdata & ~rsv_mask(mode_r); // [RQ5] [RQ6]
    end
    if (wr_deep) begin
      deep_nxt = reg_wdata[DEEP_BIT];
    end
    if (wr_cfg) begin
      ref_nxt = reg_wdata[REF_BIT]; // [RQ11]
      mode_nxt = mcm_mode_t'(reg_wdata[MODE_LSB +: 2]); // [RQ12]
      skip_nxt = skip_r & ~rsv_mask(mcm_mode_t'(reg_wdata[MODE_LSB +: 2]));
    end
    case (st_r)
      ST_SHUTDOWN, ST_DEEP: begin
        if (run_bit) begin
          st_nxt = ST_RUN;
        end else if (wr_shot && reg_wdata[SHOT_BIT]) begin
          st_nxt = ST_SHOT; // [RQ7] [RQ13]
          start_nxt = 1'b1;
        end else if (deep_nxt) begin
          st_nxt = ST_DEEP; // [RQ9]
        end else begin
          st_nxt = ST_SHUTDOWN;
        end
      end
      ST_RUN: begin
        if (!run_bit) begin
          st_nxt = deep_nxt ? ST_DEEP : ST_SHUTDOWN; // [RQ9]
        end
      end
      ST_SHOT: begin
        if (pass_done) begin
          st_nxt = deep_nxt ? ST_DEEP : ST_SHUTDOWN; // [RQ8]
        end
      end
      default: st_nxt = ST_SHUTDOWN;
    endcase
    conv_nxt = (st_nxt == ST_RUN) || (st_nxt == ST_SHOT); // [RQ14]
    dsl_nxt = (st_nxt == ST_DEEP);
  end

  // ---------------------------------------------------------------------
  // read data, clears and slot gating
  // ---------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    hit_nxt = reg_rd && any_hit;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_SKIP: rdata_nxt = skip_r;
        ADDR_SHOT: rdata_nxt = 8'h00; // [RQ13]
        ADDR_DEEP: rdata_nxt = {7'h00, deep_r};
        ADDR_CFG: rdata_nxt = {5'h00, mode_r, ref_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
    clr_nxt = wr_skip || wr_cfg; // [RQ2] [RQ10]
    rsv_nxt = rsv_mask(mode_nxt);
    for (int i = 0; i < NUM_SLOTS; i++) begin
      en_nxt[i] = !skip_nxt[i] && !rsv_nxt[i]; // [RQ3] [RQ4]
      evok_nxt[i] = en_r[i] && slot_event[i]; // [RQ3]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_r <= RST_SKIP;
      deep_r <= RST_DEEP[DEEP_BIT];
      ref_r <= RST_CFG[REF_BIT];
      mode_r <= MODE_0;
      st_r <= ST_SHUTDOWN;
      start_r <= 1'b0;
      rdata_r <= 8'h00;
      hit_r <= 1'b0;
      clr_r <= 1'b0;
      en_r <= 8'hFF;
      evok_r <= 8'h00;
      conv_r <= 1'b0;
      dsl_r <= 1'b0;
    end else begin
      skip_r <= skip_nxt;
      deep_r <= deep_nxt;
      ref_r <= ref_nxt;
      mode_r <= mode_nxt;
      st_r <= st_nxt;
      start_r <= start_nxt;
      rdata_r <= rdata_nxt;
      hit_r <= hit_nxt;
      clr_r <= clr_nxt;
      en_r <= en_nxt;
      evok_r <= evok_nxt;
      conv_r <= conv_nxt;
      dsl_r <= dsl_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_hit = hit_r;
  assign clear_results = clr_r;
  assign slot_enable = en_r;
  assign slot_event_ok = evok_r;
  assign pass_start = start_r;
  assign converting = conv_r; // [RQ14]
  assign deep_sleep = dsl_r;
  assign ext_ref_sel = ref_r;
  assign pair_mode = mode_r;

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  sequence s_shot_req;
    !run_bit && wr_shot && reg_wdata[SHOT_BIT] &&
    (st_r == ST_SHUTDOWN || st_r == ST_DEEP);
  endsequence
  property p_clear_on_write;
    @(posedge clk) disable iff (!rst_n)
      (wr_skip || wr_cfg) |=> clear_results;
  endproperty
  a_clear_on_write: assert property (p_clear_on_write) // [RQ2] [RQ10]
    else $error("clear not pulsed after mask or config write");
  property p_no_clear;
    @(posedge clk) disable iff (!rst_n)
      !(wr_skip || wr_cfg) |=> !clear_results;
  endproperty
  a_no_clear: assert property (p_no_clear) // [RQ2]
    else $error("spurious clear pulse");
  property p_skip_gate;
    @(posedge clk) disable iff (!rst_n)
      (slot_enable != 8'hFF) |=>
        ((slot_event_ok & ~$past(slot_enable)) == 8'h00);
  endproperty
  a_skip_gate: assert property (p_skip_gate) // [RQ3]
    else $error("event passed for skipped slot");
  property p_mode2_rsv;
    @(posedge clk) disable iff (!rst_n)
      (pair_mode == MODE_2) |-> (slot_enable[6:4] == 3'h0);
  endproperty
  a_mode2_rsv: assert property (p_mode2_rsv) // [RQ5]
    else $error("reserved slot enabled in mode 2");
  property p_mode3_rsv;
    @(posedge clk) disable iff (!rst_n)
      (pair_mode == MODE_3) |-> !slot_enable[6];
  endproperty
  a_mode3_rsv: assert property (p_mode3_rsv) // [RQ6]
    else $error("reserved slot enabled in mode 3");
  property p_shot_start;
    @(posedge clk) disable iff (!rst_n)
      s_shot_req |=> pass_start && converting ##1 !pass_start;
  endproperty
  a_shot_start: assert property (p_shot_start) // [RQ7] [RQ14]
    else $error("single shot did not start a pass");
  property p_shot_return;
    @(posedge clk) disable iff (!rst_n)
      (st_r == ST_SHOT && pass_done) |=>
        (deep_sleep == $past(deep_nxt)) && !converting;
  endproperty
  a_shot_return: assert property (p_shot_return) // [RQ8]
    else $error("wrong state after single shot pass");
  property p_deep_entry;
    @(posedge clk) disable iff (!rst_n)
      (st_r == ST_SHUTDOWN && !run_bit && !wr_shot && wr_deep &&
       reg_wdata[DEEP_BIT]) |=> deep_sleep;
  endproperty
  a_deep_entry: assert property (p_deep_entry) // [RQ9]
    else $error("deep shutdown not entered");
  property p_cfg_fields;
    @(posedge clk) disable iff (!rst_n)
      wr_cfg |=> ext_ref_sel == $past(reg_wdata[0]) &&
        pair_mode == mcm_mode_t'($past(reg_wdata[2:1]));
  endproperty
  a_cfg_fields: assert property (p_cfg_fields) // [RQ11] [RQ12]
    else $error("config fields not taken");
  property p_shot_reads_zero;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == ADDR_SHOT) |=> reg_rdata == 8'h00;
  endproperty
  a_shot_reads_zero: assert property (p_shot_reads_zero) // [RQ13]
    else $error("single shot register read non zero");
endmodule
`default_nettype wire

//--- testbench/mcm_seq_model.sv
// partner model: sequencer that answers a pass start with a done pulse
`timescale 1ns/1ps
`default_nettype none
module mcm_seq_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pass_start,
  input wire logic slow,
  output logic pass_done
);
  int cnt_r;
  // ---------------------------------------------------------------
  // pass length: short or long, one-cycle done pulse at the end
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 0;
      pass_done <= 1'b0;
    end else begin
      pass_done <= (cnt_r == 1);
      if (pass_start) begin
        cnt_r <= slow ? 40 : 3;
      end else if (cnt_r > 0) begin
        cnt_r <= cnt_r - 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/mcm_ctrl_tb.sv
// testbench: directed checks of the channel mode control
`timescale 1ns/1ps
`default_nettype none
module mcm_ctrl_tb;
  import mcm_pkg::*;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, run_bit = 0, slow = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, slot_event = 8'hFF;
  logic [7:0] reg_rdata, slot_enable, slot_event_ok;
  logic reg_hit, clear_results, pass_start, converting, deep_sleep;
  logic ext_ref_sel, pass_done, clr_q, start_q;
  mcm_mode_t pair_mode;
  int fail_count = 0, checks = 0, cyc = 0;
  typedef struct {logic [7:0] cfg, skip, rd, en;} mcm_row_t;
  // cfg write, skip write, skip readback, expected slot enables
  mcm_row_t rows [4] = '{'{8'hF9, 8'h81, 8'h81, 8'h7E},
    '{8'h03, 8'h55, 8'h55, 8'hAA}, '{8'h04, 8'hFF, 8'h8F, 8'h00},
    '{8'h06, 8'h7F, 8'h3F, 8'h80}};
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      summarize();
    end
  end
  mcm_ctrl i_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .run_bit(run_bit),
    .pass_done(pass_done), .slot_event(slot_event),
    .clear_results(clear_results), .slot_enable(slot_enable),
    .slot_event_ok(slot_event_ok), .pass_start(pass_start),
    .converting(converting), .deep_sleep(deep_sleep),
    .ext_ref_sel(ext_ref_sel), .pair_mode(pair_mode));
  mcm_seq_model i_seq (.clk(clk), .rst_n(rst_n), .pass_start(pass_start),
    .slow(slow), .pass_done(pass_done));
  task summarize;
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task b1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
    clr_q = clear_results;
    start_q = pass_start;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
    b1(reg_hit, hit);
  endtask
  task wait_idle;
    int n;
    n = 0;
    while (converting !== 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    b1(converting, 1'b0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 8; a < 12; a++) rd(8'(a), 8'h00, 1'b1);
    chk(slot_enable, 8'hFF);
    b1(deep_sleep, 1'b0);
    rd(8'h0C, 8'h00, 1'b0);
    foreach (rows[i]) begin
      wr(ADDR_CFG, rows[i].cfg);
      b1(clr_q, 1'b1);
      b1(ext_ref_sel, rows[i].cfg[0]);
      chk({6'h00, pair_mode}, {6'h00, rows[i].cfg[2:1]});
      rd(ADDR_CFG, rows[i].cfg & 8'h07, 1'b1);
      wr(ADDR_SKIP, rows[i].skip);
      b1(clr_q, 1'b1);
      rd(ADDR_SKIP, rows[i].rd, 1'b1);
      chk(slot_enable, rows[i].en);
      chk(slot_event_ok, rows[i].en);
    end
    wr(ADDR_CFG, 8'h04);
    rd(ADDR_SKIP, 8'h0F, 1'b1);
    wr(ADDR_SKIP, 8'h00);
    wr(ADDR_SHOT, 8'h00);
    b1(start_q, 1'b0);
    wr(ADDR_SHOT, 8'h01);
    b1(start_q, 1'b1);
    b1(converting, 1'b1);
    rd(ADDR_SHOT, 8'h00, 1'b1);
    wait_idle();
    b1(deep_sleep, 1'b0);
    wr(ADDR_DEEP, 8'h01);
    b1(deep_sleep, 1'b1);
    rd(ADDR_DEEP, 8'h01, 1'b1);
    @(posedge clk);
    slow <= 1'b1;
    wr(ADDR_SHOT, 8'hFF);
    b1(start_q, 1'b1);
    wait_idle();
    b1(deep_sleep, 1'b1);
    @(posedge clk);
    run_bit <= 1'b1;
    @(posedge clk);
    #1;
    b1(converting, 1'b1);
    wr(ADDR_SHOT, 8'h01);
    b1(start_q, 1'b0);
    @(posedge clk);
    run_bit <= 1'b0;
    wait_idle();
    b1(deep_sleep, 1'b1);
    @(posedge clk);
    slot_event <= 8'h5A;
    @(posedge clk);
    #1;
    chk(slot_event_ok, 8'h0A);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    b1(deep_sleep, 1'b0);
    chk(slot_enable, 8'hFF);
    rd(ADDR_CFG, 8'h00, 1'b1);
    rd(ADDR_DEEP, 8'h00, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
